// >>> core/brm_pkg.sv
// Constants shared by the rate resolution and management register block.
// Assumes one 40 MHz system clock and a synchronous active-high reset.
// How it works
// - Resolved speed code drives the rate adaptation speed input of the core.
// - Speed code: 10 is 1 Gbps, 01 is 100 Mbps, 00 is 10 Mbps.
// - Forced speed when negotiation off; partner or advertised by role; 1G in 1000X.
// - Six management registers: control, status, advert, partner, expansion, ext.
// - MDIO style: registers reached over the serial management interface.
// - Host-bus style: same registers reached over a parallel host bus.
// - Control and advert writable; status, partner, expansion, ext read-only.
// - Evaluation build stops working after about four hours.
// - Serial side runs 1.25 Gbps; 8b/10b coding done in the transceiver.
// - Role chosen by a pin; PCS flavour may change while running.
// - Control bit 15 resets the channel and clears itself.
// - In 1000BASE-X the control speed bits read as 10.

package brm_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [4:0] ADDR_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_STATUS = 5'h01;
   localparam logic [4:0] ADDR_ADVERT = 5'h04;
   localparam logic [4:0] ADDR_PARTNER = 5'h05;
   localparam logic [4:0] ADDR_EXPANSION = 5'h06;
   localparam logic [4:0] ADDR_EXT_STATUS = 5'h0f;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int unsigned CTRL_RESET_BIT = 15;
   localparam int unsigned CTRL_LOOPBACK_BIT = 14;
   localparam int unsigned CTRL_SPEED_LSB_BIT = 13;
   localparam int unsigned CTRL_AN_EN_BIT = 12;
   localparam int unsigned CTRL_PWRDN_BIT = 11;
   localparam int unsigned CTRL_ISOLATE_BIT = 10;
   localparam int unsigned CTRL_AN_RESTART_BIT = 9;
   localparam int unsigned CTRL_SPEED_MSB_BIT = 6;
   localparam int unsigned CTRL_UNIDIR_BIT = 5;
   localparam logic [15:0] CTRL_RESET_VAL = 16'h1140;
   localparam logic [15:0] CTRL_WRITE_MASK = 16'h7d60;
   localparam logic [15:0] ADVERT_RESET_VAL = 16'h0800;
   localparam int unsigned ADVERT_SPEED_LSB = 10;
   localparam int unsigned PARTNER_SPEED_LSB = 10;
   localparam int unsigned STAT_EXT_BIT = 8;
   localparam int unsigned STAT_AN_DONE_BIT = 5;
   localparam int unsigned STAT_AN_ABLE_BIT = 3;
   localparam int unsigned STAT_LINK_BIT = 2;
   localparam int unsigned EXP_PAGE_RX_BIT = 1;
   localparam logic [15:0] EXT_STATUS_VAL = 16'hc000;

   // ------------------------------------------------------------
   // Speed codes
   // ------------------------------------------------------------
   localparam logic [1:0] SPEED_1G = 2'h2;
   localparam logic [1:0] SPEED_100M = 2'h1;
   localparam logic [1:0] SPEED_10M = 2'h0;

   // ------------------------------------------------------------
   // Serial management framing
   // ------------------------------------------------------------
   localparam logic [5:0] MDIO_PREAMBLE_LEN = 6'h20;
   localparam logic [1:0] MDIO_OP_READ = 2'h2;
   localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
   localparam logic [5:0] MDIO_OP_LAST = 6'h01;
   localparam logic [5:0] MDIO_ADDR_LAST = 6'h09;
   localparam logic [5:0] MDIO_DATA_LAST = 6'h0f;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam longint unsigned CLK_HZ = 40000000;
   localparam longint unsigned EVAL_TIME_S = 14400;
   localparam logic [39:0] EVAL_CYCLES = 40'(EVAL_TIME_S * CLK_HZ);
   localparam int unsigned LINE_RATE_MBPS = 1250;

endpackage : brm_pkg

// >>> core/brm_rate.sv
// Speed resolution for the rate adaptation stages of the PCS core.
// Forces the 10 code itself in 1000BASE-X operation, whatever the forced speed reads.
`timescale 1ns/1ps
`default_nettype none

module brm_rate (
   // Clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Resolution inputs
   input wire logic pcs_flavour_select_i,
   input wire logic sgmii_phy_role_i,
   input wire logic an_enable_i,
   input wire logic [1:0] forced_speed_i,
   input wire logic [1:0] advertised_speed_i,
   input wire logic [1:0] partner_speed_i,
   // Resolved speed
   output logic [1:0] op_rate_o
);

   typedef struct packed {
      logic [1:0] rate;
   } brm_rate_state_t;

   brm_rate_state_t s_reg;
   brm_rate_state_t s_next;

   always_comb begin
      s_next = s_reg;
      if (pcs_flavour_select_i)
         s_next.rate = brm_pkg::SPEED_1G;
      else if (!an_enable_i)
         s_next.rate = forced_speed_i;
      else if (sgmii_phy_role_i)
         s_next.rate = advertised_speed_i;
      else
         s_next.rate = partner_speed_i;
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i)
         s_reg <= '{rate: brm_pkg::SPEED_1G};
      else if (ce_i)
         s_reg <= s_next;
   end

   assign op_rate_o = s_reg.rate;

endmodule : brm_rate

`default_nettype wire

// >>> core/brm_mdio.sv
// Serial management slave that turns frames into register strobes.
// Assumes MDC is sampled as a plain input and is slower than clk_sys_i / 2.
`timescale 1ns/1ps
`default_nettype none

module brm_mdio (
   // Clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic en_i,
   // Serial pins
   input wire logic [4:0] phy_addr_i,
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_o,
   // Register strobes
   output logic rd_o,
   output logic wr_o,
   output logic [4:0] addr_o,
   output logic [15:0] wdata_o,
   input wire logic [15:0] rdata_i
);

   typedef enum logic [2:0] {
      PH_PRE, PH_START, PH_OP, PH_ADDR, PH_TA, PH_RDAT, PH_WDAT
   } brm_mdio_phase_t;

   typedef struct packed {
      brm_mdio_phase_t phase;
      logic mdc_q;
      logic [5:0] cnt;
      logic [1:0] op;
      logic [9:0] hdr;
      logic is_rd;
      logic [15:0] shreg;
      logic mdo;
      logic oe;
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [15:0] wdata;
   } brm_mdio_state_t;

   brm_mdio_state_t s_reg;
   brm_mdio_state_t s_next;
   logic [9:0] hdr_now;

   // Every frame needs a full preamble; suppressed preambles are not seen.
   always_comb begin
      s_next = s_reg;
      s_next.rd = 1'b0;
      s_next.wr = 1'b0;
      s_next.mdc_q = mdc_i;
      hdr_now = {s_reg.hdr[8:0], mdio_i};
      // Capture data in the strobe cycle, before any clear-on-read lands.
      if (s_reg.rd)
         s_next.shreg = rdata_i;
      if (!en_i) begin
         s_next.phase = PH_PRE;
         s_next.cnt = '0;
         s_next.oe = 1'b0;
      end else if (mdc_i && !s_reg.mdc_q) begin
         unique case (s_reg.phase)
            PH_PRE: begin
               if (mdio_i) begin
                  if (s_reg.cnt != brm_pkg::MDIO_PREAMBLE_LEN)
                     s_next.cnt = s_reg.cnt + 6'h01;
               end else if (s_reg.cnt == brm_pkg::MDIO_PREAMBLE_LEN) begin
                  s_next.phase = PH_START;
               end else begin
                  s_next.cnt = '0;
               end
            end
            PH_START: begin
               s_next.cnt = '0;
               s_next.phase = mdio_i ? PH_OP : PH_PRE;
            end
            PH_OP: begin
               s_next.op = {s_reg.op[0], mdio_i};
               s_next.cnt = s_reg.cnt + 6'h01;
               if (s_reg.cnt == brm_pkg::MDIO_OP_LAST) begin
                  s_next.phase = PH_ADDR;
                  s_next.cnt = '0;
               end
            end
            PH_ADDR: begin
               s_next.hdr = hdr_now;
               s_next.cnt = s_reg.cnt + 6'h01;
               if (s_reg.cnt == brm_pkg::MDIO_ADDR_LAST) begin
                  s_next.cnt = '0;
                  s_next.addr = hdr_now[4:0];
                  s_next.is_rd = (s_reg.op == brm_pkg::MDIO_OP_READ);
                  s_next.rd = (s_reg.op == brm_pkg::MDIO_OP_READ);
                  s_next.phase = PH_TA;
                  // Foreign address or bad opcode: wait for the next frame.
                  if (hdr_now[9:5] != phy_addr_i ||
                      (s_reg.op != brm_pkg::MDIO_OP_READ &&
                       s_reg.op != brm_pkg::MDIO_OP_WRITE)) begin
                     s_next.rd = 1'b0;
                     s_next.phase = PH_PRE;
                  end
               end
            end
            PH_TA: begin
               s_next.cnt = s_reg.cnt + 6'h01;
               if (s_reg.cnt == 6'h00) begin
                  s_next.oe = s_reg.is_rd;
                  s_next.mdo = 1'b0;
               end else begin
                  s_next.cnt = '0;
                  s_next.phase = s_reg.is_rd ? PH_RDAT : PH_WDAT;
                  if (s_reg.is_rd) begin
                     s_next.mdo = s_reg.shreg[15];
                     s_next.shreg = {s_reg.shreg[14:0], 1'b0};
                  end
               end
            end
            PH_RDAT: begin
               s_next.cnt = s_reg.cnt + 6'h01;
               s_next.mdo = s_reg.shreg[15];
               s_next.shreg = {s_reg.shreg[14:0], 1'b0};
               if (s_reg.cnt == brm_pkg::MDIO_DATA_LAST) begin
                  s_next.oe = 1'b0;
                  s_next.cnt = '0;
                  s_next.phase = PH_PRE;
               end
            end
            PH_WDAT: begin
               s_next.wdata = {s_reg.wdata[14:0], mdio_i};
               s_next.cnt = s_reg.cnt + 6'h01;
               if (s_reg.cnt == brm_pkg::MDIO_DATA_LAST) begin
                  s_next.wr = 1'b1;
                  s_next.cnt = '0;
                  s_next.phase = PH_PRE;
               end
            end
            default: s_next.phase = PH_PRE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i)
         s_reg <= '0;
      else if (ce_i)
         s_reg <= s_next;
   end

   assign mdio_o = s_reg.mdo;
   assign mdio_oe_o = s_reg.oe;
   assign rd_o = s_reg.rd;
   assign wr_o = s_reg.wr;
   assign addr_o = s_reg.addr;
   assign wdata_o = s_reg.wdata;

endmodule : brm_mdio

`default_nettype wire

// >>> core/brm_top.sv
// Management register bank and rate resolution for a SGMII bridge.
// Assumes the PCS core consumes the control outputs in the same clock
// domain and that straps may change at any time.
`timescale 1ns/1ps
`default_nettype none

module brm_top #(
   parameter bit EVAL_BUILD = 1'b0,
   parameter logic [39:0] EVAL_CYCLES = brm_pkg::EVAL_CYCLES
) (
   // Clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,

   // Mode straps
   input wire logic pcs_flavour_select_i,
   input wire logic sgmii_phy_role_i,
   input wire logic mgmt_style_i,

   // Serial management pins
   input wire logic [4:0] phy_addr_i,
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_o,

   // Parallel host bus
   input wire logic hb_cs_i,
   input wire logic hb_wr_i,
   input wire logic [4:0] hb_addr_i,
   input wire logic [15:0] hb_wdata_i,
   output logic [15:0] hb_rdata_o,
   output logic hb_ack_o,

   // Status from the PCS core
   input wire logic link_ok_i,
   input wire logic an_complete_i,
   input wire logic page_rx_i,
   input wire logic [15:0] partner_ability_i,

   // Control to the PCS core and transceiver
   output logic [1:0] op_rate_o,
   output logic chan_reset_o,
   output logic an_restart_o,
   output logic an_enable_o,
   output logic loopback_o,
   output logic power_down_o,
   output logic isolate_o,
   output logic unidir_o,
   output logic core_run_o,
   output logic serdes_codec_en_o
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] advert;

      logic link_lat;
      logic page_lat;

      logic chan_rst;
      logic an_rst;

      logic [15:0] hb_rdata;
      logic hb_ack;

      logic [39:0] eval_cnt;
      logic expired;
      logic codec_en;
   } brm_top_state_t;

   brm_top_state_t s_reg;
   brm_top_state_t s_next;

   logic mdio_rd;
   logic mdio_wr;
   logic [4:0] mdio_addr;
   logic [15:0] mdio_wdata;
   logic [15:0] mdio_rdata;

   logic acc_rd;
   logic acc_wr;
   logic [4:0] acc_addr;
   logic [15:0] acc_wdata;

   logic [15:0] ctrl_view;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // speed bits read as 1G when gbe is set
   function automatic logic [15:0] ctrl_readback(
      input logic [15:0] ctrl,
      input logic gbe
   );
      logic [15:0] v;

      v = ctrl;
      if (gbe) begin
         v[brm_pkg::CTRL_SPEED_MSB_BIT] = brm_pkg::SPEED_1G[1];
         v[brm_pkg::CTRL_SPEED_LSB_BIT] = brm_pkg::SPEED_1G[0];
      end

      return v;
   endfunction : ctrl_readback

   function automatic logic [15:0] read_reg(
      input logic [4:0] addr,
      input brm_top_state_t st,
      input logic gbe,
      input logic an_done,
      input logic [15:0] partner
   );
      logic [15:0] v;

      v = '0;
      unique case (addr)
         brm_pkg::ADDR_CONTROL: v = ctrl_readback(st.ctrl, gbe);
         brm_pkg::ADDR_STATUS: begin
            v[brm_pkg::STAT_EXT_BIT] = 1'b1;
            v[brm_pkg::STAT_AN_DONE_BIT] = an_done;
            v[brm_pkg::STAT_AN_ABLE_BIT] = 1'b1;
            v[brm_pkg::STAT_LINK_BIT] = st.link_lat;
         end
         brm_pkg::ADDR_ADVERT: v = st.advert;
         brm_pkg::ADDR_PARTNER: v = partner;
         brm_pkg::ADDR_EXPANSION: v[brm_pkg::EXP_PAGE_RX_BIT] = st.page_lat;
         brm_pkg::ADDR_EXT_STATUS: v = brm_pkg::EXT_STATUS_VAL;
         default: v = '0;
      endcase

      return v;
   endfunction : read_reg

   // ------------------------------------------------------------
   // Serial management port
   // ------------------------------------------------------------
   // serial access path
   brm_mdio u_mdio (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .en_i(!mgmt_style_i),
      .phy_addr_i(phy_addr_i),
      .mdc_i(mdc_i),
      .mdio_i(mdio_i),
      .mdio_o(mdio_o),
      .mdio_oe_o(mdio_oe_o),
      .rd_o(mdio_rd),
      .wr_o(mdio_wr),
      .addr_o(mdio_addr),
      .wdata_o(mdio_wdata),
      .rdata_i(mdio_rdata)
   );

   assign mdio_rdata = read_reg(mdio_addr, s_reg, pcs_flavour_select_i,
                                an_complete_i, partner_ability_i);

   // ------------------------------------------------------------
   // Access selection
   // ------------------------------------------------------------
   always_comb begin
      // Only one style is live, so the two access paths never collide.
      // host bus replaces serial
      if (mgmt_style_i) begin
         acc_rd = hb_cs_i && !hb_wr_i;
         acc_wr = hb_cs_i && hb_wr_i;
         acc_addr = hb_addr_i;
         acc_wdata = hb_wdata_i;
      end else begin
         acc_rd = mdio_rd;
         acc_wr = mdio_wr;
         acc_addr = mdio_addr;
         acc_wdata = mdio_wdata;
      end
   end

   // ------------------------------------------------------------
   // Register behaviour
   // ------------------------------------------------------------
   always_comb begin
      s_next = s_reg;

      s_next.chan_rst = 1'b0;
      s_next.an_rst = 1'b0;
      s_next.hb_ack = 1'b0;

      s_next.codec_en = 1'b1;

      // Host reads answer one cycle later from a register.
      // Every host access is acked in host-bus style, so a host never waits on a dropped write.
      if (mgmt_style_i && hb_cs_i) begin
         s_next.hb_ack = 1'b1;
         if (!hb_wr_i)
            s_next.hb_rdata = read_reg(hb_addr_i, s_reg,
                                       pcs_flavour_select_i,
                                       an_complete_i, partner_ability_i);
      end

      // Link drop latches low; a status read re-arms, a drop still wins.
      s_next.link_lat = link_ok_i &&
                        ((acc_rd && acc_addr == brm_pkg::ADDR_STATUS) ||
                         s_reg.link_lat);

      // Page reception is sticky until read; a new page wins the clear.
      s_next.page_lat = page_rx_i ||
                        (s_reg.page_lat &&
                         !(acc_rd && acc_addr == brm_pkg::ADDR_EXPANSION));

      // only control and advert take writes
      if (acc_wr) begin
         unique case (acc_addr)
            brm_pkg::ADDR_CONTROL: begin
               if (acc_wdata[brm_pkg::CTRL_RESET_BIT]) begin
                  s_next.ctrl = brm_pkg::CTRL_RESET_VAL;
                  s_next.advert = brm_pkg::ADVERT_RESET_VAL;
                  s_next.chan_rst = 1'b1;
               end else begin
                  s_next.ctrl = acc_wdata & brm_pkg::CTRL_WRITE_MASK;
                  s_next.an_rst = acc_wdata[brm_pkg::CTRL_AN_RESTART_BIT];
               end
            end
            brm_pkg::ADDR_ADVERT: s_next.advert = acc_wdata;
            default: s_next.advert = s_reg.advert;
         endcase
      end

      // The count stops once expired, so it never wraps back to running.
      // evaluation time limit
      if (EVAL_BUILD && !s_reg.expired) begin
         s_next.eval_cnt = s_reg.eval_cnt + 40'h1;
         if (s_reg.eval_cnt == EVAL_CYCLES - 40'h1)
            s_next.expired = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         s_reg <= '0;
         s_reg.ctrl <= brm_pkg::CTRL_RESET_VAL;
         s_reg.advert <= brm_pkg::ADVERT_RESET_VAL;
      end else if (ce_i) begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------
   // Rate resolution
   // ------------------------------------------------------------
   assign ctrl_view = ctrl_readback(s_reg.ctrl, pcs_flavour_select_i);

   brm_rate u_rate (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .pcs_flavour_select_i(pcs_flavour_select_i),
      .sgmii_phy_role_i(sgmii_phy_role_i),
      .an_enable_i(s_reg.ctrl[brm_pkg::CTRL_AN_EN_BIT]),
      .forced_speed_i({ctrl_view[brm_pkg::CTRL_SPEED_MSB_BIT],
                       ctrl_view[brm_pkg::CTRL_SPEED_LSB_BIT]}),
      .advertised_speed_i(
         s_reg.advert[brm_pkg::ADVERT_SPEED_LSB +: 2]),
      .partner_speed_i(
         partner_ability_i[brm_pkg::PARTNER_SPEED_LSB +: 2]),
      .op_rate_o(op_rate_o)
   );

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign hb_rdata_o = s_reg.hb_rdata;
   assign hb_ack_o = s_reg.hb_ack;

   assign chan_reset_o = s_reg.chan_rst;
   assign an_restart_o = s_reg.an_rst;

   assign an_enable_o = s_reg.ctrl[brm_pkg::CTRL_AN_EN_BIT];
   assign loopback_o = s_reg.ctrl[brm_pkg::CTRL_LOOPBACK_BIT];
   assign power_down_o = s_reg.ctrl[brm_pkg::CTRL_PWRDN_BIT];
   assign isolate_o = s_reg.ctrl[brm_pkg::CTRL_ISOLATE_BIT];
   assign unidir_o = s_reg.ctrl[brm_pkg::CTRL_UNIDIR_BIT];

   // An expired evaluation build holds the channel idle until reset.
   assign core_run_o = !s_reg.expired;
   assign serdes_codec_en_o = s_reg.codec_en;

endmodule : brm_top

`default_nettype wire

// >>> tb/brm_top_properties.sv
// Checker for the management register bank and rate resolution block.
// Assumes it is bound to brm_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module brm_top_properties (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Straps and host bus
   input wire logic pcs_flavour_select_i,
   input wire logic sgmii_phy_role_i,
   input wire logic mgmt_style_i,
   input wire logic hb_cs_i,
   input wire logic hb_wr_i,
   input wire logic [4:0] hb_addr_i,
   input wire logic [15:0] hb_wdata_i,
   input wire logic [15:0] hb_rdata_o,
   input wire logic hb_ack_o,
   // Rate and control
   input wire logic [15:0] partner_ability_i,
   input wire logic [1:0] op_rate_o,
   input wire logic chan_reset_o,
   input wire logic an_enable_o
);
   logic [1:0] lp_spd;
   logic take;
   assign lp_spd = partner_ability_i[11:10];
   assign take = ce_i && mgmt_style_i && hb_cs_i;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);

   property p_ack;
      take |=> hb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_noack;
      ce_i && !take |=> !hb_ack_o;
   endproperty
   a_noack: assert property (p_noack) else $error("stray ack");
   property p_gbe;
      ce_i && pcs_flavour_select_i |=> op_rate_o == brm_pkg::SPEED_1G;
   endproperty
   a_gbe: assert property (p_gbe) else $error("rate not 1G");
   property p_mac;
      ce_i && !pcs_flavour_select_i && !sgmii_phy_role_i && an_enable_o
         |=> op_rate_o == $past(lp_spd);
   endproperty
   a_mac: assert property (p_mac) else $error("rate not partner");
   property p_ctrl_gbe;
      take && !hb_wr_i && hb_addr_i == 5'h00 && pcs_flavour_select_i
         |=> hb_rdata_o[6] && !hb_rdata_o[13];
   endproperty
   a_ctrl_gbe: assert property (p_ctrl_gbe) else $error("speed bits");
   property p_unmapped;
      take && !hb_wr_i
         && !(hb_addr_i inside {5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h0f})
         |=> hb_rdata_o == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped");
   property p_crst;
      take && hb_wr_i && hb_addr_i == 5'h00 && hb_wdata_i[15]
         |=> chan_reset_o ##1 !chan_reset_o;
   endproperty
   a_crst: assert property (p_crst) else $error("chan reset");
   property p_ext;
      take && !hb_wr_i && hb_addr_i == 5'h0f
         |=> hb_rdata_o == brm_pkg::EXT_STATUS_VAL;
   endproperty
   a_ext: assert property (p_ext) else $error("ext status");
endmodule : brm_top_properties

bind brm_top brm_top_properties brm_top_properties_i (.clk_sys_i,
   .srst_i, .ce_i, .pcs_flavour_select_i, .sgmii_phy_role_i,
   .mgmt_style_i, .hb_cs_i, .hb_wr_i, .hb_addr_i, .hb_wdata_i,
   .hb_rdata_o, .hb_ack_o, .partner_ability_i, .op_rate_o,
   .chan_reset_o, .an_enable_o);
`default_nettype wire

// >>> tb/brm_mdio_station.sv
// Serial management station model that frames reads and writes.
// Assumes a pull-up on the data line and that MDC rests low between frames.
`timescale 1ns/1ps
`default_nettype none

module brm_mdio_station (
   output logic mdc_o,
   output logic mdio_o,
   output logic mdio_oe_o,
   input wire logic mdio_i
);
   initial begin
      mdc_o = 1'b0;
      mdio_o = 1'b0;
      mdio_oe_o = 1'b0;
   end
   task automatic bit_out(input logic b);
      mdio_oe_o = 1'b1;
      mdio_o = b;
      #100;
      mdc_o = 1'b1;
      #100;
      mdc_o = 1'b0;
   endtask : bit_out
   task automatic frame(input logic [1:0] op, input logic [4:0] phy,
         input logic [4:0] ra, input logic [15:0] wd,
         output logic [15:0] rd);
      logic [45:0] hdr;
      logic [17:0] tail;
      hdr = {32'hffffffff, 2'b01, op, phy, ra};
      tail = {2'b10, wd};
      rd = 16'h0000;
      for (int i = 45; i >= 0; i--) bit_out(hdr[i]);
      if (op == 2'b01) begin
         for (int i = 17; i >= 0; i--) bit_out(tail[i]);
      end else begin
         // Turnaround and data are sampled just before each rising edge.
         mdio_oe_o = 1'b0;
         for (int i = 0; i < 18; i++) begin
            #100;
            rd = {rd[14:0], mdio_i};
            mdc_o = 1'b1;
            #100;
            mdc_o = 1'b0;
         end
      end
      mdio_oe_o = 1'b0;
      mdio_o = ~mdio_o;
   endtask : frame
endmodule : brm_mdio_station
`default_nettype wire

// >>> tb/brm_top_tb.sv
// Self-checking bench for the register bank and rate resolution block.
// Assumes the station model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module brm_top_tb;
   logic clk = 1'b0, srst = 1'b1, flav = 1'b0, role = 1'b0, style = 1'b1;
   logic cs = 1'b0, wr = 1'b0, ack, crst, run, codec, d_o, d_oe, mdc;
   logic s_o, s_oe, line;
   logic ce = 1'b1, anc = 1'b0, pg = 1'b0;
   logic [4:0] ctl;
   logic [4:0] addr = 5'h00;
   logic [15:0] wdata = 16'h0000, partner = 16'h0000, rdata, rd;
   logic [1:0] rate;
   int bad_count = 0, checks = 0;
   // The released line floats high through the pull-up.
   assign line = d_oe ? d_o : (s_oe ? s_o : 1'b1);
   always #12.5 clk = ~clk;

   brm_top #(.EVAL_BUILD(1'b1), .EVAL_CYCLES(40'd20)) brm_top_i (
      .clk_sys_i(clk), .srst_i(srst), .ce_i(ce),
      .pcs_flavour_select_i(flav), .sgmii_phy_role_i(role),
      .mgmt_style_i(style), .phy_addr_i(5'h03), .mdc_i(mdc),
      .mdio_i(line), .mdio_o(d_o), .mdio_oe_o(d_oe), .hb_cs_i(cs),
      .hb_wr_i(wr), .hb_addr_i(addr), .hb_wdata_i(wdata),
      .hb_rdata_o(rdata), .hb_ack_o(ack), .link_ok_i(1'b1),
      .an_complete_i(anc), .page_rx_i(pg),
      .partner_ability_i(partner), .op_rate_o(rate),
      .chan_reset_o(crst), .an_restart_o(ctl[4]), .an_enable_o(),
      .loopback_o(ctl[3]), .power_down_o(ctl[2]), .isolate_o(ctl[1]),
      .unidir_o(ctl[0]), .core_run_o(run), .serdes_codec_en_o(codec));
   brm_mdio_station brm_mdio_station_i (.mdc_o(mdc), .mdio_o(s_o),
      .mdio_oe_o(s_oe), .mdio_i(line));

   task automatic end_sim;
      if (bad_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [15:0] e, g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tick;
      @(posedge clk);
      #2;
   endtask : tick
   task automatic hb(input logic w, input logic [4:0] a,
         input logic [15:0] d, input logic ack_exp);
      tick;
      cs = 1'b1;
      wr = w;
      addr = a;
      wdata = d;
      tick;
      cs = 1'b0;
      rd = rdata;
      chk("ack", {15'h0, ack_exp}, {15'h0, ack});
   endtask : hb
   task automatic rate_is(input logic [1:0] e);
      tick;
      tick;
      chk("rate", {14'h0, e}, {14'h0, rate});
   endtask : rate_is
   task automatic t_regs;
      hb(0, 5'h00, 0, 1); chk("ctrl", 16'h1140, rd);
      hb(0, 5'h04, 0, 1); chk("adv", 16'h0800, rd);
      anc = 1'b1;
      hb(0, 5'h01, 0, 1); chk("stat", 16'h0128, rd & 16'h012c);
      hb(0, 5'h01, 0, 1); chk("stat2", 16'h012c, rd & 16'h012c);
      pg = 1'b1;
      tick;
      pg = 1'b0;
      hb(0, 5'h06, 0, 1); chk("page", 16'h0002, rd);
      hb(0, 5'h06, 0, 1); chk("page2", 16'h0000, rd);
      hb(1, 5'h0f, 16'h0000, 1); hb(0, 5'h0f, 0, 1);
      chk("ext", 16'hc000, rd);
      partner = 16'h0400;
      hb(1, 5'h05, 16'hffff, 1); hb(0, 5'h05, 0, 1);
      chk("lp", 16'h0400, rd);
      hb(1, 5'h02, 16'hffff, 1); hb(0, 5'h02, 0, 1);
      chk("unmap", 16'h0000, rd);
   endtask : t_regs
   task automatic t_rate;
      hb(1, 5'h04, 16'h0000, 1);
      rate_is(2'h1);
      ce = 1'b0;
      role = 1'b1;
      rate_is(2'h1);
      ce = 1'b1;
      rate_is(2'h0);
      hb(1, 5'h00, 16'h2100, 1);
      rate_is(2'h1);
      flav = 1'b1;
      rate_is(2'h2);
      hb(0, 5'h00, 0, 1); chk("ctrl_gbe", 16'h0140, rd);
      flav = 1'b0;
      hb(1, 5'h00, 16'h0000, 1);
      rate_is(2'h0);
   endtask : t_rate
   task automatic t_crst;
      hb(1, 5'h00, 16'h4e20, 1); chk("ctl", 16'h001f, {11'h0, ctl});
      hb(1, 5'h00, 16'h8000, 1); chk("crst", 16'h0001, {15'h0, crst});
      hb(0, 5'h00, 0, 1); chk("ctrl_def", 16'h1140, rd);
      chk("ctl_def", 16'h0000, {11'h0, ctl});
   endtask : t_crst
   task automatic t_mdio;
      style = 1'b0;
      hb(0, 5'h04, 0, 0);
      brm_mdio_station_i.frame(2'b01, 5'h03, 5'h04, 16'h0400, rd);
      brm_mdio_station_i.frame(2'b10, 5'h03, 5'h04, 16'h0000, rd);
      chk("mdio_rd", 16'h0400, rd);
      brm_mdio_station_i.frame(2'b10, 5'h07, 5'h04, 16'h0000, rd);
      chk("mdio_phy", 16'hffff, rd);
      style = 1'b1;
      hb(0, 5'h04, 0, 1); chk("adv_hb", 16'h0400, rd);
   endtask : t_mdio

   initial begin
      repeat (20) tick;
      srst = 1'b0;
      t_regs;
      t_rate;
      t_crst;
      t_mdio;
      chk("run", 16'h0000, {15'h0, run});
      chk("codec", 16'h0001, {15'h0, codec});
      end_sim;
   end
   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      end_sim;
   end
endmodule : brm_top_tb
`default_nettype wire
